// ===== core/clock_tree_div.sv
// Derives cpu, machine-cycle and peripheral enables from the oscillator clock.
`timescale 1ns/100ps
module clock_tree_div
  import sysinit_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  clock_tree_if.tree ct
);
  logic [7:0] div_q, div_d;
  logic phase_q, phase_d;
  logic cpu_d, mach_d, per_d;
  logic cpu_q, mach_q, per_q;

  // ==========================================================
  // Divider
  always_comb begin
    div_d = div_q;
    phase_d = phase_q;
    cpu_d = 1'b0;
    mach_d = 1'b0;
    per_d = 1'b0;
    if (div_q >= ct.cpu_div) begin
      div_d = 8'h00;
      cpu_d = 1'b1;
      phase_d = ~phase_q;
      // machine cycle spans two cpu clocks
      mach_d = phase_q;
      // peripheral rate is cpu over two
      per_d = phase_q;
    end else begin
      div_d = div_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      phase_q <= 1'b0;
      cpu_q <= 1'b0;
      mach_q <= 1'b0;
      per_q <= 1'b0;
    end else begin
      div_q <= div_d;
      phase_q <= phase_d;
      cpu_q <= cpu_d;
      mach_q <= mach_d;
      per_q <= per_d;
    end
  end

  assign ct.cpu_en = cpu_q;
  assign ct.machine_en = mach_q;
  assign ct.periph_en = per_q;

  // peripheral enable only with a cpu enable
  chk_periph_with_cpu: assert property (@(posedge clk) disable iff (!rst_n)
    per_q |-> cpu_q) else $error("peripheral enable without cpu enable");
endmodule

// ===== core/clock_tree_if.sv
// Signals between the init register bank and the clock-tree divider.
`timescale 1ns/100ps
interface clock_tree_if;
  logic [7:0] cpu_div;
  logic cpu_en;
  logic machine_en;
  logic periph_en;
  modport bank (output cpu_div, input cpu_en, input machine_en, input periph_en);
  modport tree (input cpu_div, output cpu_en, output machine_en, output periph_en);
endinterface

// ===== core/sysinit_bank.sv
// Reset-source dependent init registers, extended register bank and clock tree.
`timescale 1ns/100ps
// How it works
// - Port pins come up as inputs.
// - Cause register accumulates a flag per reset source.
// - Power-on leaves only power and brownout flags.
// - Watchdog control resets to 1110 01x1.
// - Timeout flag set by watchdog, cleared power-on.
// - Oscillator trim reloads on power-on or watchdog.
// - Power/watchdog-only registers survive other resets.
// - Brownout irq config copied from option byte.
// - Clock select and doubler from option bytes.
// - Amplifier gain trims reload on power/watchdog.
// - Extended bank answers at aux data addresses.
// - Oscillator clock chosen from four sources.
// - Cpu clock from divider, two per machine.
// - Peripheral clock is cpu clock halved.
// - RC oscillator nominal, doubled when enabled.
// - Crystal selectable for oscillator and watchdog.
// - Switch status low during switch, auto-set when done.
module sysinit_bank
  import sysinit_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = 8'h20,
  parameter logic [7:0] FACTORY_AMP_TRIM = 8'h88
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire reset_src_t RESET_SRC,
  // Option bytes
  input wire logic [7:0] OPTION_BYTE_ONE,
  input wire logic [7:0] OPTION_BYTE_TWO,
  // Auxiliary data space access
  input wire logic AUX_WR,
  input wire logic AUX_RD,
  input wire logic [15:0] AUX_ADDR,
  input wire logic [7:0] AUX_WDATA,
  output logic [7:0] AUX_RDATA,
  output logic AUX_HIT,
  // Status and configuration
  output logic [7:0] RESET_CAUSE,
  output logic [7:0] WD_CONTROL,
  output logic [7:0] OSC_TRIM,
  output logic [7:0] CLOCK_CONTROL,
  output logic [1:0] OSC_SOURCE_SEL,
  output logic CLOCK_DOUBLER,
  output logic CRYSTAL_WD,
  // Port pins
  output logic [PORT_PINS-1:0] PORT_OE_N,
  // Clock tree enables
  output logic CPU_EN,
  output logic MACHINE_EN,
  output logic PERIPH_EN
);
  clock_tree_if ct();

  logic [7:0] cause_q, cause_d, wdc_q, wdc_d, trim_q, trim_d;
  logic [7:0] clk_q, clk_d, bod_q, bod_d;
  logic [7:0] rtcl_q, rtcl_d, rtch_q, rtch_d;
  logic [7:0] a0c_q, a0c_d, a0b_q, a0b_d, a1c_q, a1c_d, a1b_q, a1b_d;
  logic [7:0] a0tl_q, a0tl_d, a0th_q, a0th_d, a1tl_q, a1tl_d, a1th_q, a1th_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic [2:0] settle_q, settle_d;
  logic [2:0] sel_q, sel_d;
  logic pow_rst, wd_rst, deep_rst;
  logic [PORT_PINS-1:0] oe_n_q, oe_n_d;

  // ==========================================================
  // Reset classification
  // classify reset source
  assign pow_rst = !RESET_N && (RESET_SRC == SRC_POWER_ON);
  assign wd_rst = !RESET_N && (RESET_SRC == SRC_WATCHDOG);
  assign deep_rst = pow_rst || wd_rst;

  // ==========================================================
  // Register bank next state
  always_comb begin
    cause_d = cause_q;
    wdc_d = wdc_q;
    trim_d = trim_q;
    clk_d = clk_q;
    bod_d = bod_q;
    rtcl_d = rtcl_q;
    rtch_d = rtch_q;
    a0c_d = a0c_q;
    a0b_d = a0b_q;
    a1c_d = a1c_q;
    a1b_d = a1b_q;
    a0tl_d = a0tl_q;
    a0th_d = a0th_q;
    a1tl_d = a1tl_q;
    a1th_d = a1th_q;
    settle_d = settle_q;
    sel_d = sel_q;
    rdata_d = rdata_q;
    hit_d = 1'b0;
    oe_n_d = oe_n_q;
    if (!RESET_N) begin
      // record the cause of this reset
      cause_d = cause_q;
      if (pow_rst) begin
        cause_d = RST_CAUSE_POWER_ON;
      end else if (wd_rst) begin
        cause_d[CAUSE_WATCHDOG_BIT] = 1'b1;
      end else begin
        cause_d[CAUSE_OTHER_BIT] = 1'b1;
      end
      wdc_d = RST_WD_CONTROL;
      // timeout flag depends on reset source
      wdc_d[WD_TIMEOUT_BIT] = wd_rst ? 1'b1 : (pow_rst ? 1'b0 : wdc_q[WD_TIMEOUT_BIT]);
      // clock select and doubler from option bytes
      // done bit set, upper bits cleared
      clk_d = {1'b1, 3'h0, OPTION_BYTE_TWO[OPT2_DOUBLER_BIT], OPTION_BYTE_ONE[2:0]};
      settle_d = 3'h0;
      sel_d = OPTION_BYTE_ONE[2:0];
      a0c_d = RST_ZERO;
      a0b_d = RST_ZERO;
      a1c_d = RST_ZERO;
      a1b_d = RST_ZERO;
      // every port pin back to input
      oe_n_d = {PORT_PINS{1'b1}};
      if (pow_rst) begin
        // brownout irq config from option byte one
        bod_d = {6'h00, OPTION_BYTE_ONE[OPT1_BOI_HI_BIT], OPTION_BYTE_ONE[OPT1_BOI_LO_BIT]};
      end
      // only deep resets touch these registers
      if (deep_rst) begin
        trim_d = FACTORY_TRIM;
        a0tl_d = FACTORY_AMP_TRIM;
        a0th_d = FACTORY_AMP_TRIM;
        a1tl_d = FACTORY_AMP_TRIM;
        a1th_d = FACTORY_AMP_TRIM;
        rtcl_d = RST_ZERO;
        rtch_d = RST_ZERO;
      end
    end else begin
      if (!clk_q[CLK_DONE_BIT]) begin
        settle_d = settle_q + 3'h1;
        if (settle_q == SWITCH_SETTLE_CYCLES) begin
          clk_d[CLK_DONE_BIT] = 1'b1;
          sel_d = clk_q[2:0];
        end
      end
      if (AUX_WR) begin
        unique case (AUX_ADDR)
          ADDR_RTC_DATA_LOW: rtcl_d = AUX_WDATA;
          ADDR_RTC_DATA_HIGH: rtch_d = AUX_WDATA;
          ADDR_BROWNOUT_CONFIG: bod_d = AUX_WDATA & BROWNOUT_CFG_MASK;
          ADDR_AMP0_CONTROL: a0c_d = AUX_WDATA;
          ADDR_AMP0_GAIN_TRIM_LOW: a0tl_d = AUX_WDATA;
          ADDR_AMP0_GAIN_TRIM_HIGH: a0th_d = AUX_WDATA;
          ADDR_AMP0_CONTROL_B: a0b_d = AUX_WDATA & AMP_CONTROL_B_MASK;
          ADDR_AMP1_CONTROL: a1c_d = AUX_WDATA;
          ADDR_AMP1_GAIN_TRIM_LOW: a1tl_d = AUX_WDATA;
          ADDR_AMP1_GAIN_TRIM_HIGH: a1th_d = AUX_WDATA;
          ADDR_AMP1_CONTROL_B: a1b_d = AUX_WDATA & AMP_CONTROL_B_MASK;
          ADDR_CLOCK_CONTROL: begin
            // a new switch clears the done bit
            if (clk_q[CLK_DONE_BIT]) begin
              clk_d = {1'b0, 2'h0, AUX_WDATA[4:0] & CLK_CTRL_WR_MASK[4:0]};
              settle_d = 3'h0;
            end
          end
          default: ;
        endcase
      end
      if (AUX_RD) begin
        hit_d = 1'b1;
        unique case (AUX_ADDR)
          ADDR_RTC_DATA_LOW: rdata_d = rtcl_q;
          ADDR_RTC_DATA_HIGH: rdata_d = rtch_q;
          ADDR_BROWNOUT_CONFIG: rdata_d = bod_q;
          ADDR_AMP0_CONTROL: rdata_d = a0c_q;
          ADDR_AMP0_GAIN_TRIM_LOW: rdata_d = a0tl_q;
          ADDR_AMP0_GAIN_TRIM_HIGH: rdata_d = a0th_q;
          ADDR_AMP0_CONTROL_B: rdata_d = a0b_q;
          ADDR_AMP1_CONTROL: rdata_d = a1c_q;
          ADDR_AMP1_GAIN_TRIM_LOW: rdata_d = a1tl_q;
          ADDR_AMP1_GAIN_TRIM_HIGH: rdata_d = a1th_q;
          ADDR_AMP1_CONTROL_B: rdata_d = a1b_q;
          ADDR_CLOCK_CONTROL: rdata_d = clk_q;
          default: begin
            rdata_d = RST_ZERO;
            hit_d = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  // Reset is synchronous, so the reset branch above is simply the next state.
  always_ff @(posedge SYS_CLK) begin
    cause_q <= cause_d;
    wdc_q <= wdc_d;
    trim_q <= trim_d;
    clk_q <= clk_d;
    bod_q <= bod_d;
    rtcl_q <= rtcl_d;
    rtch_q <= rtch_d;
    a0c_q <= a0c_d;
    a0b_q <= a0b_d;
    a1c_q <= a1c_d;
    a1b_q <= a1b_d;
    a0tl_q <= a0tl_d;
    a0th_q <= a0th_d;
    a1tl_q <= a1tl_d;
    a1th_q <= a1th_d;
    settle_q <= settle_d;
    sel_q <= sel_d;
    rdata_q <= rdata_d;
    hit_q <= hit_d;
    oe_n_q <= oe_n_d;
  end

  // ==========================================================
  // Clock tree
  // cpu divider ratio set by the latched select bits sel_q, counted on SYS_CLK
  assign ct.cpu_div = {5'h00, sel_q};
  clock_tree_div u_div (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .ct(ct.tree)
  );

  logic cpu_q, mach_q, per_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cpu_q <= 1'b0;
      mach_q <= 1'b0;
      per_q <= 1'b0;
    end else begin
      cpu_q <= ct.cpu_en;
      mach_q <= ct.machine_en;
      per_q <= ct.periph_en;
    end
  end

  // ==========================================================
  // Outputs
  assign RESET_CAUSE = cause_q;
  assign WD_CONTROL = wdc_q;
  assign OSC_TRIM = trim_q;
  assign CLOCK_CONTROL = clk_q;
  // two select bits pick one of four sources
  assign OSC_SOURCE_SEL = sel_q[1:0];
  assign CLOCK_DOUBLER = clk_q[CLK_DOUBLER_BIT];
  assign CRYSTAL_WD = clk_q[4];
  // pins tristated, a software port block overrides later
  assign PORT_OE_N = oe_n_q;
  assign AUX_RDATA = rdata_q;
  assign AUX_HIT = hit_q;
  assign CPU_EN = cpu_q;
  assign MACHINE_EN = mach_q;
  assign PERIPH_EN = per_q;

  // ==========================================================
  // Checks
  chk_poweron_cause: assert property (@(posedge SYS_CLK)
    pow_rst |=> cause_q == RST_CAUSE_POWER_ON) else $error("power-on cause wrong");
  chk_wd_control_reset: assert property (@(posedge SYS_CLK)
    !RESET_N |=> (wdc_q & ~(8'h01 << WD_TIMEOUT_BIT)) ==
    (RST_WD_CONTROL & ~(8'h01 << WD_TIMEOUT_BIT))) else $error("wd control reset");
  chk_timeout_wd: assert property (@(posedge SYS_CLK)
    wd_rst |=> wdc_q[WD_TIMEOUT_BIT]) else $error("timeout flag not set");
  chk_timeout_other: assert property (@(posedge SYS_CLK)
    (!RESET_N && !deep_rst) |=> $stable(wdc_q[WD_TIMEOUT_BIT])) else $error("timeout changed");
  chk_trim_kept: assert property (@(posedge SYS_CLK)
    (!RESET_N && !deep_rst) |=> $stable(trim_q)) else $error("trim reloaded");
  chk_trim_loaded: assert property (@(posedge SYS_CLK)
    deep_rst |=> trim_q == FACTORY_TRIM) else $error("trim not loaded");
  chk_amp_trim_kept: assert property (@(posedge SYS_CLK)
    (!RESET_N && !deep_rst) |=> $stable(a0tl_q) && $stable(a1th_q)) else $error("amp trim");
  chk_clock_ctrl_reset: assert property (@(posedge SYS_CLK)
    !RESET_N |=> clk_q[7:4] == 4'h8) else $error("clock control reset");
  chk_switch_done: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $fell(clk_q[CLK_DONE_BIT]) |-> ##[1:6] clk_q[CLK_DONE_BIT]) else $error("switch stuck");
  chk_machine_pair: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    mach_q |-> cpu_q) else $error("machine enable without cpu");
  chk_cause_watchdog: assert property (@(posedge SYS_CLK)
    wd_rst |=> cause_q[CAUSE_WATCHDOG_BIT]) else $error("watchdog cause not recorded");
  chk_brownout_copy: assert property (@(posedge SYS_CLK)
    pow_rst |=> bod_q == {6'h00, $past(OPTION_BYTE_ONE[OPT1_BOI_HI_BIT]),
    $past(OPTION_BYTE_ONE[OPT1_BOI_LO_BIT])}) else $error("brownout config not copied");
  chk_busy_write_kept: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !clk_q[CLK_DONE_BIT] |=> $stable(clk_q[4:0])) else $error("write taken while switching");
  chk_port_inputs: assert property (@(posedge SYS_CLK)
    RESET_N |-> oe_n_q == {PORT_PINS{1'b1}}) else $error("port pin driven");
  chk_hit_after_read: assert property (@(posedge SYS_CLK)
    hit_q |-> $past(AUX_RD)) else $error("hit without read");
endmodule

// ===== core/sysinit_pkg.sv
// Constants and types shared by the reset-init and clock-tree block.
package sysinit_pkg;
  // ==========================================================
  // Extended register addresses in the auxiliary data space
  localparam logic [15:0] ADDR_RTC_DATA_LOW = 16'hffbe;
  localparam logic [15:0] ADDR_RTC_DATA_HIGH = 16'hffbf;
  localparam logic [15:0] ADDR_BROWNOUT_CONFIG = 16'hffc8;
  localparam logic [15:0] ADDR_AMP0_CONTROL = 16'hffca;
  localparam logic [15:0] ADDR_AMP0_GAIN_TRIM_LOW = 16'hffcc;
  localparam logic [15:0] ADDR_AMP0_GAIN_TRIM_HIGH = 16'hffcd;
  localparam logic [15:0] ADDR_AMP0_CONTROL_B = 16'hffce;
  localparam logic [15:0] ADDR_CLOCK_CONTROL = 16'hffde;
  localparam logic [15:0] ADDR_AMP1_CONTROL = 16'hffe1;
  localparam logic [15:0] ADDR_AMP1_GAIN_TRIM_LOW = 16'hffe2;
  localparam logic [15:0] ADDR_AMP1_GAIN_TRIM_HIGH = 16'hffe3;
  localparam logic [15:0] ADDR_AMP1_CONTROL_B = 16'hffe4;
  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CAUSE_POWER_ON = 8'h30;
  localparam logic [7:0] RST_WD_CONTROL = 8'he5;
  localparam logic [7:0] BROWNOUT_CFG_MASK = 8'h03;
  localparam logic [7:0] AMP_CONTROL_B_MASK = 8'h01;
  localparam logic [7:0] CLK_CTRL_WR_MASK = 8'h1f;
  localparam int CAUSE_WATCHDOG_BIT = 1;
  localparam int CAUSE_OTHER_BIT = 0;
  localparam int WD_TIMEOUT_BIT = 1;
  localparam int OPT1_BOI_HI_BIT = 5;
  localparam int OPT1_BOI_LO_BIT = 3;
  localparam int OPT2_DOUBLER_BIT = 7;
  localparam int CLK_DONE_BIT = 7;
  localparam int CLK_DOUBLER_BIT = 3;
  // ==========================================================
  // Clock tree
  localparam int OSC_SOURCES = 4;
  localparam int CPU_PER_MACHINE = 2;
  localparam int CPU_PER_PERIPH = 2;
  localparam logic [2:0] SWITCH_SETTLE_CYCLES = 3'h4;
  localparam int PORT_PINS = 8;
  // ==========================================================
  // Reset source reported by the reset controller
  typedef enum logic [1:0] {
    SRC_POWER_ON,
    SRC_WATCHDOG,
    SRC_OTHER
  } reset_src_t;
endpackage

// ===== sim/reset_init_and_clock_tree_tb_top.sv
// Self-checking bench for the reset-init register bank and clock tree.
`timescale 1ns/100ps
module reset_init_and_clock_tree_tb_top;
  import sysinit_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  localparam logic [7:0] TRIM_V = 8'h2a;
  localparam logic [7:0] AMP_V = 8'h5c;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  reset_src_t RESET_SRC = SRC_POWER_ON;
  logic [7:0] OPTION_BYTE_ONE = 8'h00;
  logic [7:0] OPTION_BYTE_TWO = 8'h00;
  logic AUX_WR = 1'b0;
  logic AUX_RD = 1'b0;
  logic [15:0] AUX_ADDR = 16'h0000;
  logic [7:0] AUX_WDATA = 8'h00;
  logic [7:0] AUX_RDATA, RESET_CAUSE, WD_CONTROL, OSC_TRIM, CLOCK_CONTROL;
  logic [1:0] OSC_SOURCE_SEL;
  logic CLOCK_DOUBLER, CRYSTAL_WD, AUX_HIT, CPU_EN, MACHINE_EN, PERIPH_EN;
  logic [PORT_PINS-1:0] PORT_OE_N;
  int num_errors = 0;
  int checks = 0;
  int n;
  logic [7:0] seed = 8'h52;
  logic [7:0] d, q;
  logic h;
  logic [7:0] trim_m;
  logic wd_tof;
  logic [7:0] model [int];
  logic [15:0] addrs [11] = '{ADDR_RTC_DATA_LOW, ADDR_RTC_DATA_HIGH, ADDR_BROWNOUT_CONFIG,
    ADDR_AMP0_CONTROL, ADDR_AMP0_GAIN_TRIM_LOW, ADDR_AMP0_GAIN_TRIM_HIGH, ADDR_AMP0_CONTROL_B,
    ADDR_AMP1_CONTROL, ADDR_AMP1_GAIN_TRIM_LOW, ADDR_AMP1_GAIN_TRIM_HIGH, ADDR_AMP1_CONTROL_B};

  sysinit_bank #(.FACTORY_TRIM(TRIM_V), .FACTORY_AMP_TRIM(AMP_V)) dut_u (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .RESET_SRC(RESET_SRC),
    .OPTION_BYTE_ONE(OPTION_BYTE_ONE), .OPTION_BYTE_TWO(OPTION_BYTE_TWO),
    .AUX_WR(AUX_WR), .AUX_RD(AUX_RD), .AUX_ADDR(AUX_ADDR), .AUX_WDATA(AUX_WDATA),
    .AUX_RDATA(AUX_RDATA), .AUX_HIT(AUX_HIT), .RESET_CAUSE(RESET_CAUSE),
    .WD_CONTROL(WD_CONTROL), .OSC_TRIM(OSC_TRIM), .CLOCK_CONTROL(CLOCK_CONTROL),
    .OSC_SOURCE_SEL(OSC_SOURCE_SEL), .CLOCK_DOUBLER(CLOCK_DOUBLER), .CRYSTAL_WD(CRYSTAL_WD),
    .PORT_OE_N(PORT_OE_N), .CPU_EN(CPU_EN), .MACHINE_EN(MACHINE_EN), .PERIPH_EN(PERIPH_EN));

  initial begin
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task aux_write(input logic [15:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    AUX_WR <= 1'b1;
    AUX_ADDR <= a;
    AUX_WDATA <= v;
    @(posedge SYS_CLK);
    AUX_WR <= 1'b0;
  endtask

  // Read data is compared against the model and hit against hit_exp, in the cycle they stand.
  task check_reg(input logic [15:0] a, input logic hit_exp);
    @(posedge SYS_CLK);
    AUX_RD <= 1'b1;
    AUX_ADDR <= a;
    @(posedge SYS_CLK);
    AUX_RD <= 1'b0;
    #1;
    check(AUX_RDATA, model.exists(a) ? model[a] : 8'h00);
    check({7'h00, AUX_HIT}, {7'h00, hit_exp});
  endtask

  task check_all;
    foreach (addrs[i]) check_reg(addrs[i], 1'b1);
    check_reg(ADDR_CLOCK_CONTROL, 1'b1);
    check_reg(16'hffc0, 1'b0);
  endtask

  task mwrite(input logic [15:0] a, input logic [7:0] v);
    case (a)
      ADDR_BROWNOUT_CONFIG: model[a] = v & BROWNOUT_CFG_MASK;
      ADDR_AMP0_CONTROL_B, ADDR_AMP1_CONTROL_B: model[a] = v & AMP_CONTROL_B_MASK;
      default: model[a] = v;
    endcase
  endtask

  // Option bytes change at every reset so stale copies are caught.
  task do_reset(input reset_src_t src);
    @(posedge SYS_CLK);
    RESET_N <= 1'b0;
    RESET_SRC <= src;
    OPTION_BYTE_ONE <= seed;
    OPTION_BYTE_TWO <= lfsr(seed);
    seed = lfsr(lfsr(seed));
    repeat (2) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    #1;
    model[ADDR_AMP0_CONTROL] = 8'h00;
    model[ADDR_AMP1_CONTROL] = 8'h00;
    model[ADDR_AMP0_CONTROL_B] = 8'h00;
    model[ADDR_AMP1_CONTROL_B] = 8'h00;
    model[ADDR_CLOCK_CONTROL] = {4'h8, OPTION_BYTE_TWO[7], OPTION_BYTE_ONE[2:0]};
    if (src == SRC_POWER_ON) begin
      model[ADDR_BROWNOUT_CONFIG] = {6'h00, OPTION_BYTE_ONE[5], OPTION_BYTE_ONE[3]};
    end
    if (src != SRC_OTHER) begin
      model[ADDR_RTC_DATA_LOW] = 8'h00;
      model[ADDR_RTC_DATA_HIGH] = 8'h00;
      model[ADDR_AMP0_GAIN_TRIM_LOW] = AMP_V;
      model[ADDR_AMP0_GAIN_TRIM_HIGH] = AMP_V;
      model[ADDR_AMP1_GAIN_TRIM_LOW] = AMP_V;
      model[ADDR_AMP1_GAIN_TRIM_HIGH] = AMP_V;
      trim_m = TRIM_V;
      wd_tof = (src == SRC_WATCHDOG);
    end
    if (src == SRC_POWER_ON) check(RESET_CAUSE, RST_CAUSE_POWER_ON);
    if (src == SRC_WATCHDOG) check({7'h00, RESET_CAUSE[CAUSE_WATCHDOG_BIT]}, 8'h01);
    if (src == SRC_OTHER) check({7'h00, RESET_CAUSE[CAUSE_OTHER_BIT]}, 8'h01);
    check(WD_CONTROL, RST_WD_CONTROL | {6'h00, wd_tof, 1'b0});
    check(OSC_TRIM, trim_m);
    check(CLOCK_CONTROL, model[ADDR_CLOCK_CONTROL]);
    check({7'h00, CLOCK_DOUBLER}, {7'h00, OPTION_BYTE_TWO[7]});
    check({6'h00, OSC_SOURCE_SEL}, {6'h00, OPTION_BYTE_ONE[1:0]});
    check({7'h00, CRYSTAL_WD}, 8'h00);
    check(PORT_OE_N, 8'hff);
    check_all;
  endtask

  // Between two machine-cycle pulses come two cpu pulses and one peripheral pulse.
  task tree_check;
    int c, p;
    c = 0;
    p = 0;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end while (MACHINE_EN !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      report_and_stop;
    end
    n = 0;
    do begin
      @(posedge SYS_CLK);
      #1;
      n++;
      c += (CPU_EN === 1'b1);
      p += (PERIPH_EN === 1'b1);
    end while (MACHINE_EN !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      report_and_stop;
    end
    check(8'(c), 8'(CPU_PER_MACHINE));
    check(8'(p), 8'h01);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    // Power-on comes first: registers without it start unknown.
    do_reset(SRC_POWER_ON);
    foreach (addrs[i]) begin
      aux_write(addrs[i], seed);
      mwrite(addrs[i], seed);
      seed = lfsr(seed);
    end
    check_all;
    do_reset(SRC_OTHER);
    do_reset(SRC_WATCHDOG);
    do_reset(SRC_OTHER);
    // Clock switches: a second write while busy must be dropped.
    for (int i = 0; i < OSC_SOURCES; i++) begin
      d = {3'h0, seed[4:3], 3'(i)};
      aux_write(ADDR_CLOCK_CONTROL, d);
      #1;
      check({7'h00, CLOCK_CONTROL[CLK_DONE_BIT]}, 8'h00);
      n = 0;
      do begin
        @(posedge SYS_CLK);
        if (n == 0) AUX_WDATA <= ~d;
        if (n == 0) AUX_WR <= 1'b1;
        if (n == 1) AUX_WR <= 1'b0;
        #1;
        n++;
      end while (CLOCK_CONTROL[CLK_DONE_BIT] !== 1'b1 && n < 20);
      check(8'(n), 8'(SWITCH_SETTLE_CYCLES) + 8'h01);
      if (n >= 20) report_and_stop;
      model[ADDR_CLOCK_CONTROL] = {3'h4, d[4:0]};
      check(CLOCK_CONTROL, model[ADDR_CLOCK_CONTROL]);
      check({7'h00, CRYSTAL_WD}, {7'h00, d[4]});
      check({7'h00, CLOCK_DOUBLER}, {7'h00, d[CLK_DOUBLER_BIT]});
      check({6'h00, OSC_SOURCE_SEL}, {6'h00, d[1:0]});
      check_reg(ADDR_CLOCK_CONTROL, 1'b1);
      tree_check;
      seed = lfsr(seed);
    end
    do_reset(SRC_POWER_ON);
    report_and_stop;
  end
endmodule
